// ===== src/ast_serial_transceiver.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "ast_consts.svh"
// Overview of operation
// R1: frame is start bit, eight or nine data bits, stop bit.
// R2: start bit is low, stop bit is high.
// R3: data bits go out and come in least significant first.
// R4: break is a line held low for whole frames.
// R5: far transmitter leaves the line idle before a message.
// R6: shifter loads only from the transmit data register.
// R7: pin driven while sending or while transmitter enabled.
// R8: completed receive word moves into the receive data register.
// R9: three samples per bit, majority decides value and cleanliness; here any disagreement of the three flags noise.
// R10: transmitter and receiver each run only when enabled.
// R11: sleeping receiver sets none of its status flags.
// R12: sleep bit written by software, cleared by hardware on wake.
// R13: idle-line wake clears sleep as soon as idle is seen.
// R14: far side leaves one idle frame between messages only.
// R15: address wake on data msb set, bit 7 or bit 8.
// R16: address wake clears sleep before the stop bit arrives.
// R17: word arriving while full sets overrun, keeps old word.
// R18: overrun clears by status read seeing it, then data read.
// R19: noise on any bit flagged with full flag, same clearing.
// R20: framing error set with full flag; overrun hides it.
// R21: framing error blocks transfers until cleared by read pair.
// R22: parity error on bad parity, cleared by read pair.
// R23: word length bit one means nine data bits.
// R24: wake select one means address mark, zero idle line.
// R25: receiver samples at sixteen times bit rate, resyncs on start.
module ast_serial_transceiver (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // serial pins
  input  wire logic        RXD,
  output logic             TXD,
  output logic             TXD_OE_N
);
  // ****************************************
  // register bus
  // ****************************************
  logic [12:0] baud;
  logic [4:0]  ctrl1;
  logic [3:0]  ctrl2;
  logic [7:0]  stat;
  logic [7:0]  seen;
  logic [8:0]  rx_data;
  logic [8:0]  tdr;
  logic        acc;
  logic        rd_stat;
  logic        rd_data;
  logic        wr_data;
  logic        wr_c2;
  logic        hit;
  logic [31:0] rd_mux;

  assign acc     = PSEL && PENABLE;
  assign hit     = PADDR == `AST_OFS_BAUD || PADDR == `AST_OFS_CTRL1 ||
                   PADDR == `AST_OFS_CTRL2 || PADDR == `AST_OFS_STAT ||
                   PADDR == `AST_OFS_DATA;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !hit;
  assign rd_stat = acc && !PWRITE && PADDR == `AST_OFS_STAT;
  assign rd_data = acc && !PWRITE && PADDR == `AST_OFS_DATA;
  assign wr_data = acc && PWRITE && PADDR == `AST_OFS_DATA;
  assign wr_c2   = acc && PWRITE && PADDR == `AST_OFS_CTRL2;

  always_comb begin
    unique case (PADDR)
      `AST_OFS_BAUD:  rd_mux = {19'h0, baud};
      `AST_OFS_CTRL1: rd_mux = {27'h0, ctrl1};
      `AST_OFS_CTRL2: rd_mux = {28'h0, ctrl2};
      `AST_OFS_STAT:  rd_mux = {24'h0, stat};
      `AST_OFS_DATA:  rd_mux = {23'h0, rx_data};
      default:        rd_mux = 32'h0;
    endcase
  end

  // read data is latched in the setup cycle so the status snapshot
  // that arms the clear sequence is exactly what software saw
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rd_mux;
    end
  end

  logic       wake_clr;
  logic       addr_evt;
  logic       idle_evt;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      baud  <= `AST_BAUD_RST;
      ctrl1 <= 5'h00;
    end else if (acc && PWRITE && PADDR == `AST_OFS_BAUD) begin
      baud  <= PWDATA[12:0];
    end else if (acc && PWRITE && PADDR == `AST_OFS_CTRL1) begin
      ctrl1 <= PWDATA[4:0];
    end
  end

  // software write wins over a wake in the same cycle
  assign wake_clr = ctrl2[`AST_C2_RXEN] && ctrl2[`AST_C2_SLEEP] &&
                    (ctrl1[`AST_C1_WAKE] ? addr_evt : idle_evt); // R24
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl2 <= 4'h0;
    end else if (wr_c2) begin
      ctrl2 <= PWDATA[3:0]; // R12
    end else if (wake_clr) begin
      ctrl2[`AST_C2_SLEEP] <= 1'b0; // R12 R13 R15
    end
  end

  logic sleep;
  logic wlen9;
  logic te;
  logic re;
  assign sleep = ctrl2[`AST_C2_SLEEP];
  assign wlen9 = ctrl1[`AST_C1_WLEN]; // R23
  assign te    = ctrl2[`AST_C2_TXEN];
  assign re    = ctrl2[`AST_C2_RXEN];

  // ****************************************
  // sample clock divider
  // ****************************************
  logic [12:0] div_cnt;
  logic        tick;
  assign tick = (te || re) && baud != 13'h0 && div_cnt <= 13'h0001;
  always_ff @(posedge CLK) begin
    if (SRST || tick || !(te || re)) begin
      div_cnt <= baud;
    end else begin
      div_cnt <= div_cnt - 13'h0001;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  ast_pkg::ast_rx_state_t rx_st;
  logic       rx_meta;
  logic       rx_in;
  logic [3:0] rx_ph;
  logic [3:0] rx_bit;
  logic [8:0] rx_sh;
  logic       s7;
  logic       s8;
  logic       vote;
  logic       noisy;
  logic       noise_acc;
  logic       eval;
  logic       rx_done;
  logic       rx_last;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rx_meta <= 1'b1;
      rx_in   <= 1'b1;
    end else begin
      rx_meta <= RXD;
      rx_in   <= rx_meta;
    end
  end

  assign vote    = (s7 && s8) || (s7 && rx_in) || (s8 && rx_in); // R9
  assign noisy   = !(s7 == s8 && s8 == rx_in); // R9
  assign eval    = tick && rx_ph == `AST_VOTE_C && rx_st != ast_pkg::RX_IDLE;
  assign rx_last = rx_bit == (wlen9 ? 4'h8 : 4'h7);
  assign rx_done = eval && rx_st == ast_pkg::RX_STOP;
  assign addr_evt = eval && rx_st == ast_pkg::RX_DATA && rx_last && vote; // R15 R16

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s7 <= 1'b1;
      s8 <= 1'b1;
    end else if (tick) begin
      if (rx_ph == `AST_VOTE_A) begin
        s7 <= rx_in;
      end
      if (rx_ph == `AST_VOTE_B) begin
        s8 <= rx_in;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST || !re) begin // R10
      rx_st     <= ast_pkg::RX_IDLE;
      rx_ph     <= 4'h0;
      rx_bit    <= 4'h0;
      rx_sh     <= 9'h000;
      noise_acc <= 1'b0;
    end else if (tick) begin
      rx_ph <= rx_ph + 4'h1;
      unique case (rx_st)
        ast_pkg::RX_IDLE: begin
          rx_ph <= 4'h1; // R25
          if (!rx_in) begin
            rx_st <= ast_pkg::RX_START;
          end
        end
        ast_pkg::RX_START: begin
          if (eval) begin
            rx_st     <= vote ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA; // R2
            rx_bit    <= 4'h0;
            rx_sh     <= 9'h000;
            noise_acc <= noisy; // R19
          end
        end
        ast_pkg::RX_DATA: begin
          if (eval) begin
            rx_sh[rx_bit] <= vote; // R3
            rx_bit        <= rx_bit + 4'h1;
            noise_acc     <= noise_acc || noisy;
            if (rx_last) begin
              rx_st <= ast_pkg::RX_STOP; // R1
            end
          end
        end
        ast_pkg::RX_STOP: begin
          if (eval) begin
            rx_st <= ast_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // idle line: long type starts counting only once the frame is over
  logic [7:0] idle_cnt;
  logic [7:0] idle_thr;
  assign idle_thr = wlen9 ? `AST_IDLE_T9 : `AST_IDLE_T8;
  assign idle_evt = re && tick && rx_in && idle_cnt == idle_thr - 8'h01;
  always_ff @(posedge CLK) begin
    if (SRST || !re || !rx_in) begin
      idle_cnt <= 8'h00;
    end else if (ctrl1[`AST_C1_ILT] && rx_st != ast_pkg::RX_IDLE) begin
      idle_cnt <= 8'h00;
    end else if (tick && idle_cnt != idle_thr) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  logic deliver;
  logic overrun;
  assign deliver = rx_done && !sleep && !stat[`AST_ST_FE] && !stat[`AST_ST_RECEIVE_FULL_FLAG]; // R21
  assign overrun = rx_done && !sleep && !stat[`AST_ST_FE] && stat[`AST_ST_RECEIVE_FULL_FLAG]; // R17

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rx_data <= 9'h000;
    end else if (deliver) begin
      rx_data <= rx_sh; // R8
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  logic [10:0] tx_sh;
  logic [3:0]  tx_ph;
  logic [3:0]  tx_left;
  logic        tx_busy;
  logic        tx_load;
  logic        brk_load;
  logic        tx_end;
  logic [10:0] next_frame;
  logic [8:0]  dp9;
  logic [7:0]  dp8;

  assign brk_load = !tx_busy && te && ctrl2[`AST_C2_BRK];
  assign tx_load  = !tx_busy && te && !ctrl2[`AST_C2_BRK] && !stat[`AST_ST_TDRE]; // R10
  assign tx_end   = tx_busy && tick && tx_ph == `AST_OVS_LAST && tx_left == 4'h1;
  assign dp9 = ctrl1[`AST_C1_PEN] ? {^tdr[7:0] ^ ctrl1[`AST_C1_PODD], tdr[7:0]} : tdr;
  assign dp8 = ctrl1[`AST_C1_PEN] ? {^tdr[6:0] ^ ctrl1[`AST_C1_PODD], tdr[6:0]}
                                  : tdr[7:0];
  assign next_frame = wlen9 ? {1'b1, dp9, 1'b0} : {2'b11, dp8, 1'b0}; // R1 R2

  always_ff @(posedge CLK) begin
    if (SRST) begin
      tx_sh   <= 11'h7FF;
      tx_ph   <= 4'h0;
      tx_left <= 4'h0;
      tx_busy <= 1'b0;
    end else if (tx_load || brk_load) begin
      tx_sh   <= tx_load ? next_frame : {!wlen9, 10'h000}; // R6 R4
      tx_ph   <= 4'h0;
      tx_left <= wlen9 ? 4'hB : 4'hA;
      tx_busy <= 1'b1;
    end else if (tx_busy && tick) begin
      tx_ph <= tx_ph + 4'h1;
      if (tx_ph == `AST_OVS_LAST) begin
        // a break that goes on must not show a one-cycle high between frames
        tx_sh   <= (tx_left == 4'h1 && te && ctrl2[`AST_C2_BRK]) ? 11'h000
                                                                 : {1'b1, tx_sh[10:1]}; // R3 R4
        tx_left <= tx_left - 4'h1;
        tx_busy <= tx_left != 4'h1;
      end
    end
  end

  assign TXD      = tx_sh[0];
  assign TXD_OE_N = !(tx_busy || te); // R7

  always_ff @(posedge CLK) begin
    if (SRST) begin
      tdr <= 9'h000;
    end else if (wr_data) begin
      tdr <= PWDATA[8:0];
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  logic [7:0] st_set;
  logic [7:0] st_clr;
  logic       rx_pbad;
  assign rx_pbad = ctrl1[`AST_C1_PEN] && ((^rx_sh) != ctrl1[`AST_C1_PODD]);

  always_comb begin
    st_set = 8'h00;
    st_set[`AST_ST_TDRE] = tx_load;
    st_set[`AST_ST_TC]   = tx_end && !(te && (ctrl2[`AST_C2_BRK] ||
                           !stat[`AST_ST_TDRE]));
    st_set[`AST_ST_RECEIVE_FULL_FLAG] = deliver; // R11
    st_set[`AST_ST_IDLE] = idle_evt && !sleep; // R11
    st_set[`AST_ST_OR]   = overrun; // R17 R20
    st_set[`AST_ST_NF]   = deliver && (noise_acc || noisy); // R19
    st_set[`AST_ST_FE]   = deliver && !vote; // R20
    st_set[`AST_ST_PF]   = deliver && rx_pbad; // R22
    st_clr = (rd_data ? (seen & `AST_RX_CLR) : 8'h00) |
             (wr_data ? (seen & `AST_TX_CLR) : 8'h00);
  end

  // a set in the same cycle as the clear survives
  always_ff @(posedge CLK) begin
    if (SRST) begin
      stat <= `AST_STAT_RST;
      seen <= 8'h00;
    end else begin
      stat <= (stat & ~st_clr) | st_set; // R18 R19 R21 R22
      seen <= rd_stat ? PRDATA[7:0] : (seen & ~st_clr);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_load;
    tx_load;
  endsequence
  sequence s_start_bit;
    (TXD == 1'b0) [*3];
  endsequence

  property p_start_low;
    s_load |=> s_start_bit;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // R2

  property p_from_tdr;
    tx_load && !wlen9 && !ctrl1[`AST_C1_PEN] |=> tx_sh[8:1] == $past(tdr[7:0]);
  endproperty
  a_from_tdr: assert property (p_from_tdr) else $error("shifter not from data reg"); // R6

  property p_drive;
    $rose(te) |=> !TXD_OE_N;
  endproperty
  a_drive: assert property (p_drive) else $error("pin not driven"); // R7

  property p_sleep_quiet;
    rx_done && sleep |=> stat[5:0] == $past(stat[5:0]) || $past(rd_data);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("flag set asleep"); // R11

  property p_overrun;
    overrun |=> stat[`AST_ST_OR] && $stable(rx_data) && !$rose(stat[`AST_ST_FE]);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun mishandled"); // R17

  property p_fe_block;
    rx_done && stat[`AST_ST_FE] |=> $stable(rx_data);
  endproperty
  a_fe_block: assert property (p_fe_block) else $error("transfer despite fe"); // R21

  property p_or_clear;
    rd_data && seen[`AST_ST_OR] && !overrun |=> !stat[`AST_ST_OR];
  endproperty
  a_or_clear: assert property (p_or_clear) else $error("overrun not cleared"); // R18

  property p_idle_wake;
    idle_evt && sleep && re && !ctrl1[`AST_C1_WAKE] && !wr_c2 |=> !sleep;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("no idle wake"); // R13

  property p_addr_wake;
    addr_evt && sleep && re && ctrl1[`AST_C1_WAKE] && !wr_c2
      |=> !sleep ##[1:300] (rx_st == ast_pkg::RX_STOP);
  endproperty
  a_addr_wake: assert property (p_addr_wake) else $error("no address wake"); // R16

  property p_fe_with_receive_full_flag;
    $rose(stat[`AST_ST_FE]) |-> $rose(stat[`AST_ST_RECEIVE_FULL_FLAG]);
  endproperty
  a_fe_with_receive_full_flag: assert property (p_fe_with_receive_full_flag) else $error("fe without receive_full_flag"); // R20
endmodule

// ===== pkg/ast_consts.svh
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define AST_OFS_BAUD  8'h00
`define AST_OFS_CTRL1 8'h04
`define AST_OFS_CTRL2 8'h08
`define AST_OFS_STAT  8'h0C
`define AST_OFS_DATA  8'h10
// ****************************************
// field positions
// ****************************************
`define AST_C1_WLEN  4
`define AST_C1_WAKE  3
`define AST_C1_ILT   2
`define AST_C1_PEN   1
`define AST_C1_PODD  0
`define AST_C2_TXEN  3
`define AST_C2_RXEN  2
`define AST_C2_SLEEP 1
`define AST_C2_BRK   0
`define AST_ST_TDRE  7
`define AST_ST_TC    6
`define AST_ST_RECEIVE_FULL_FLAG  5
`define AST_ST_IDLE  4
`define AST_ST_OR    3
`define AST_ST_NF    2
`define AST_ST_FE    1
`define AST_ST_PF    0
// ****************************************
// reset values, clear masks and timing
// ****************************************
`define AST_BAUD_RST  13'h0004
`define AST_STAT_RST  8'hC0
`define AST_RX_CLR    8'h3F
`define AST_TX_CLR    8'hC0
`define AST_OVS_LAST  4'hF
`define AST_VOTE_A    4'h7
`define AST_VOTE_B    4'h8
`define AST_VOTE_C    4'h9
`define AST_IDLE_T8   8'hA0
`define AST_IDLE_T9   8'hB0
`endif

// ===== pkg/ast_pkg.sv
package ast_pkg;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } ast_rx_state_t;
endpackage

// ===== tb/ast_far_node.sv
`timescale 1ns/100ps
module ast_far_node #(
  parameter int BITCLK = 16
) (
  // clock
  input  wire logic clk,
  // line from the device, word length in use
  input  wire logic txd,
  input  wire logic nine,
  // line into the device
  output logic      rxd
);
  logic [9:0]  rxq[$];
  logic [9:0]  sh;
  logic [10:0] fr;
  int          n;
  // line rests high before any message
  initial rxd = 1'b1;
  // g flips one clock mid-bit to provoke noise; -1 for none
  task automatic send(input logic [8:0] d, input logic stp, input int g);
    int i;
    int j;
    fr = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (i = 0; i < (nine ? 11 : 10); i++) begin
      for (j = 0; j < BITCLK; j++) begin
        rxd <= (i == g && j == 8) ? ~fr[i] : fr[i];
        @(posedge clk);
      end
    end
    // one clock high after a frame with a low stop bit, otherwise no gap between frames
    if (!stp) begin
      rxd <= 1'b1;
      @(posedge clk);
    end
  endtask
  // frames from the device: data bits then stop bit
  initial begin
    forever begin
      @(negedge txd);
      sh = '0;
      repeat (BITCLK / 2) @(posedge clk);
      for (n = 0; n < (nine ? 10 : 9); n++) begin
        repeat (BITCLK) @(posedge clk);
        sh[n] = txd;
      end
      rxq.push_back(sh);
    end
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`include "ast_consts.svh"
module tb_top;
  logic        clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        txd_oe_n;
  logic        nine;
  logic        lerr;
  logic [31:0] rv;
  logic [8:0]  d;
  logic [8:0]  dq[3];
  int          err_total;
  int          cmp_count;
  int          seed;
  int          i;
  int          k;
  ast_serial_transceiver ast_serial_transceiver_inst (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RXD(rxd), .TXD(txd), .TXD_OE_N(txd_oe_n)
  );
  ast_far_node #(.BITCLK(16)) ast_far_node_inst (
    .clk(clk), .txd(txd), .nine(nine), .rxd(rxd)
  );
  always #50 clk = ~clk;
  // ********
  // checking and bus tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic bail(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  // idle cycle after release, so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bail(n, 20);
    rv = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_stat(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, `AST_OFS_STAT, 32'h0);
      n++;
    end while ((rv[7:0] & m) !== m && n < 400);
    bail(n, 400);
  endtask
  task automatic rx(input logic [8:0] dd, input logic stp, input int g, input logic [7:0] es);
    ast_far_node_inst.send(dd, stp, g);
    wait_stat(8'h20);
    chk("rxstat", rv & 32'h2F, {24'h0, es});
  endtask
  function automatic logic [9:0] exp_tx(input logic [8:0] v);
    return nine ? {1'b1, v} : {2'b01, v[7:0]};
  endfunction
  // ********
  // main sequence
  // ********
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nine = 1'b0;
    err_total = 0;
    cmp_count = 0;
    seed = 32'h1FF118C4;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `AST_OFS_BAUD, 32'h0);
    chk("baud", rv, 32'h4);
    apb(1'b0, `AST_OFS_STAT, 32'h0);
    chk("stat", rv, 32'hC0);
    chk("oe_idle", {31'h0, txd_oe_n}, 32'h1);
    apb(1'b1, 8'h14, 32'hFFFF);
    chk("slverr", {31'h0, lerr}, 32'h1);
    apb(1'b1, `AST_OFS_BAUD, 32'h1);
    apb(1'b1, `AST_OFS_CTRL2, 32'hC);
    chk("oe_en", {31'h0, txd_oe_n}, 32'h0);
    // transmit, three queued words per length
    for (k = 0; k < 2; k++) begin
      nine = k[0];
      apb(1'b1, `AST_OFS_CTRL1, {27'h0, k[0], 4'h0});
      for (i = 0; i < 3; i++) begin
        dq[i] = 9'($random(seed));
        wait_stat(8'h80);
        apb(1'b1, `AST_OFS_DATA, {23'h0, dq[i]});
      end
      i = 0;
      while (ast_far_node_inst.rxq.size() < 3 && i < 2000) begin
        @(posedge clk);
        i++;
      end
      bail(i, 2000);
      for (i = 0; i < 3; i++) begin
        chk("txfrm", {22'h0, ast_far_node_inst.rxq.pop_front()}, {22'h0, exp_tx(dq[i])});
      end
    end
    nine = 1'b0;
    apb(1'b1, `AST_OFS_CTRL1, 32'h0);
    // receive with corner values, then overrun
    for (i = 0; i < 4; i++) begin
      d = (i < 2) ? {1'b0, {8{i[0]}}} : {1'b0, 8'($random(seed))};
      rx(d, 1'b1, -1, 8'h20);
      apb(1'b0, `AST_OFS_DATA, 32'h0);
      chk("rxdata", rv, {23'h0, d});
    end
    ast_far_node_inst.send(9'h03C, 1'b1, -1);
    rx(9'h0C3, 1'b1, -1, 8'h28);
    apb(1'b0, `AST_OFS_DATA, 32'h0);
    chk("ordata", rv, 32'h3C);
    apb(1'b0, `AST_OFS_STAT, 32'h0);
    chk("orclr", rv & 32'h2F, 32'h0);
    // framing fault, parity good and bad, noise
    rx(9'h055, 1'b0, -1, 8'h22);
    apb(1'b0, `AST_OFS_DATA, 32'h0);
    apb(1'b0, `AST_OFS_STAT, 32'h0);
    chk("feclr", rv & 32'h2F, 32'h0);
    apb(1'b1, `AST_OFS_CTRL1, 32'h2);
    for (i = 0; i < 2; i++) begin
      d = {2'b0, 7'($random(seed))};
      d[7] = (^d[6:0]) ^ i[0];
      rx(d, 1'b1, -1, {7'h10, i[0]});
      apb(1'b0, `AST_OFS_DATA, 32'h0);
    end
    apb(1'b1, `AST_OFS_CTRL1, 32'h0);
    rx(9'h0B6, 1'b1, 3, 8'h24);
    apb(1'b0, `AST_OFS_DATA, 32'h0);
    chk("nfdata", rv, 32'hB6);
    // receiver disabled
    apb(1'b1, `AST_OFS_CTRL2, 32'h8);
    ast_far_node_inst.send(9'h011, 1'b1, -1);
    repeat (20) @(posedge clk);
    apb(1'b0, `AST_OFS_STAT, 32'h0);
    chk("rxoff", rv & 32'h20, 32'h0);
    // idle-line wake: sleep set mid-message
    fork
      ast_far_node_inst.send(9'h0A5, 1'b1, -1);
      begin
        repeat (40) @(posedge clk);
        apb(1'b1, `AST_OFS_CTRL2, 32'hE);
      end
    join
    ast_far_node_inst.send(9'h05A, 1'b1, -1);
    repeat (20) @(posedge clk);
    apb(1'b0, `AST_OFS_STAT, 32'h0);
    chk("slpstat", rv & 32'h2F, 32'h0);
    apb(1'b0, `AST_OFS_CTRL2, 32'h0);
    chk("slpset", rv, 32'hE);
    repeat (220) @(posedge clk);
    apb(1'b0, `AST_OFS_CTRL2, 32'h0);
    chk("idlwake", rv, 32'hC);
    // address-mark wake in both lengths
    for (k = 0; k < 2; k++) begin
      nine = k[0];
      apb(1'b1, `AST_OFS_CTRL1, {27'h0, k[0], 4'h8});
      apb(1'b1, `AST_OFS_CTRL2, 32'hE);
      d = 9'($random(seed)) & (k[0] ? 9'h0FF : 9'h07F);
      ast_far_node_inst.send(d, 1'b1, -1);
      repeat (20) @(posedge clk);
      apb(1'b0, `AST_OFS_STAT, 32'h0);
      chk("adrslp", rv & 32'h2F, 32'h0);
      d[k[0] ? 8 : 7] = 1'b1;
      rx(d, 1'b1, -1, 8'h20);
      apb(1'b0, `AST_OFS_CTRL2, 32'h0);
      chk("adrwake", rv, 32'hC);
      apb(1'b0, `AST_OFS_DATA, 32'h0);
      chk("adrdata", rv, {23'h0, d});
    end
    // break holds the line low
    apb(1'b1, `AST_OFS_CTRL2, 32'h9);
    for (i = 0; i < 6; i++) begin
      repeat (50) @(posedge clk);
      chk("brk", {31'h0, txd}, 32'h0);
    end
    apb(1'b1, `AST_OFS_CTRL2, 32'hC);
    tally_and_finish();
  end
endmodule
